/* src/ssl_pkg.sv */
package ssl_pkg;
  localparam logic [7:0] SSL_OFF_STATUS = 8'h30;
  localparam logic [7:0] SSL_OFF_CORE_LEVEL = 8'h34;
  localparam logic [7:0] SSL_OFF_PLL_LEVEL = 8'h40;
  localparam logic [7:0] SSL_OFF_IRQ_STATUS = 8'h50;
  localparam logic [7:0] SSL_OFF_IRQ_ENABLE = 8'h54;
  localparam logic [7:0] SSL_OFF_IRQ_CLEAR = 8'h58;
  localparam logic [7:0] SSL_OFF_STRAPS = 8'h5C;
  localparam int SSL_BIT_OSC_STABLE = 24;
  localparam int SSL_BIT_PLL_GOOD = 19;
  localparam int SSL_BIT_CORE_GOOD = 16;
  localparam int SSL_BIT_ANA_ILIM = 9;
  localparam int SSL_BIT_CORE_ILIM = 8;
  localparam int SSL_BIT_ANA_SOFT = 1;
  localparam int SSL_BIT_CORE_SOFT = 0;
  localparam int SSL_CORE_LEVEL_W = 7;
  localparam int SSL_PLL_LEVEL_W = 3;
  localparam int SSL_NUM_FLAGS = 7;
  localparam int SSL_STRAP_W = 2;
  localparam logic [31:0] SSL_STATUS_MASK = 32'h0109_0303;
  localparam logic [31:0] SSL_UNMAPPED_DATA = 32'h0000_0000;
  localparam logic [6:0] SSL_CORE_LEVEL_MAX = 7'h46;
  // Cycles after reset until the strap sync holds pin values
  localparam logic [1:0] SSL_STRAP_SETTLE = 2'h2;
  // Reset level codes, indexed by strap setting
  localparam logic [3:0][6:0] SSL_STRAP_CORE_LEVEL = {7'h37, 7'h32, 7'h2D, 7'h28};
  localparam logic [3:0][2:0] SSL_STRAP_PLL_LEVEL = {3'h6, 3'h6, 3'h5, 3'h4};
endpackage

/* src/ssl_strap_decode.sv */
`timescale 1ns/1ps
module ssl_strap_decode (
  input wire logic [ssl_pkg::SSL_STRAP_W-1:0] strap_i,
  output logic [ssl_pkg::SSL_CORE_LEVEL_W-1:0] core_level_o,
  output logic [ssl_pkg::SSL_PLL_LEVEL_W-1:0] pll_level_o
);
  // Default codes per strap setting; core code n is 0.60 V + n*10 mV
  always_comb begin
    core_level_o = ssl_pkg::SSL_STRAP_CORE_LEVEL[strap_i];
    pll_level_o = ssl_pkg::SSL_STRAP_PLL_LEVEL[strap_i];
  end
endmodule // ssl_strap_decode

/* src/ssl_supply_regs.sv */
`timescale 1ns/1ps
// What this block does, and what software must do
// [R01] Bit 24 shows oscillator stable, read-only
// [R02] Bit 19 shows PLL supply rail good
// [R03] Bit 16 shows core supply rail good
// [R04] Bits 9/8 show converter current limiting
// [R05] Bits 1/0 show converter soft-start
// [R06] Status word at 0x30 is read-only, live
// [R07] Core level bits 6:0, 0.60 V + n*10 mV
// [R08] Level fields reset to strap-chosen codes
// [R09] Software ramps core level 10 mV per microsecond
// [R10] PLL level bits 2:0, 0.6 V + n*100 mV
// [R11] Software raises PLL level one code at a time
// [R12] Each converter or regulator feeds its own rail
// [R13] Reserved bits ignore writes, read zero
module ssl_supply_regs (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [ssl_pkg::SSL_STRAP_W-1:0] strap_i,
  input wire logic osc_stable_i,
  input wire logic pll_supply_rail_good_i,
  input wire logic core_supply_rail_good_i,
  input wire logic analogue_buck_converter_ilim_i,
  input wire logic core_buck_converter_ilim_i,
  input wire logic analogue_buck_converter_soft_i,
  input wire logic core_buck_converter_soft_i,
  output logic [ssl_pkg::SSL_CORE_LEVEL_W-1:0] core_buck_converter_level_o,
  output logic [ssl_pkg::SSL_PLL_LEVEL_W-1:0] pll_linear_regulator_level_o,
  output logic irq_o
);
  localparam int NF = ssl_pkg::SSL_NUM_FLAGS;
  localparam int CW = ssl_pkg::SSL_CORE_LEVEL_W;
  localparam int PW = ssl_pkg::SSL_PLL_LEVEL_W;
  localparam int SW = ssl_pkg::SSL_STRAP_W;

  typedef struct packed {
    logic [CW-1:0] core_level;
    logic [PW-1:0] pll_level;
    logic [NF-1:0] flags_prev;
    logic [NF-1:0] irq_status;
    logic [NF-1:0] irq_enable;
    logic [SW-1:0] strap_latched;
    logic [1:0] settle;
    logic ack;
    logic [31:0] rdata;
  } ssl_state_t;

  ssl_state_t state;
  ssl_state_t next_state;

  logic [NF-1:0] flags_raw;
  logic [NF-1:0] flags;
  logic [SW-1:0] strap_sync;
  logic [CW-1:0] strap_core;
  logic [PW-1:0] strap_pll;
  logic [31:0] status_word;
  logic [NF-1:0] flag_change;
  logic [NF-1:0] clear_hit;
  logic access;

  // Byte-enable merge of a write into a narrow field held in the low byte
  function automatic logic [7:0] ssl_merge_low(input logic [7:0] old_v,
                                               input logic [31:0] wdata,
                                               input logic [3:0] be);
    ssl_merge_low = be[0] ? wdata[7:0] : old_v;
  endfunction

  // Packs a flag vector into the status word layout
  function automatic logic [31:0] ssl_pack_status(input logic [NF-1:0] f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ssl_pkg::SSL_BIT_CORE_SOFT] = f[0];
    w[ssl_pkg::SSL_BIT_ANA_SOFT] = f[1];
    w[ssl_pkg::SSL_BIT_CORE_ILIM] = f[2];
    w[ssl_pkg::SSL_BIT_ANA_ILIM] = f[3];
    w[ssl_pkg::SSL_BIT_CORE_GOOD] = f[4];
    w[ssl_pkg::SSL_BIT_PLL_GOOD] = f[5];
    w[ssl_pkg::SSL_BIT_OSC_STABLE] = f[6];
    ssl_pack_status = w & ssl_pkg::SSL_STATUS_MASK;
  endfunction

  // Analogue indications arrive unsynchronised
  assign flags_raw = {osc_stable_i, pll_supply_rail_good_i, core_supply_rail_good_i,
                      analogue_buck_converter_ilim_i, core_buck_converter_ilim_i,
                      analogue_buck_converter_soft_i, core_buck_converter_soft_i};

  ssl_sync #(
    .WIDTH(NF)
  ) u_flag_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(flags_raw),
    .sync_o(flags)
  );

  ssl_sync #(
    .WIDTH(SW)
  ) u_strap_sync (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .async_i(strap_i),
    .sync_o(strap_sync)
  );

  ssl_strap_decode u_strap_decode (
    .strap_i(strap_sync),
    .core_level_o(strap_core),
    .pll_level_o(strap_pll)
  );

  assign status_word = ssl_pack_status(flags); // [R01] [R02] [R03] [R04] [R05]
  assign flag_change = flags ^ state.flags_prev;
  assign access = (avs_read_i || avs_write_i) && !state.ack;
  assign clear_hit = (avs_write_i && state.ack
                      && avs_address_i == ssl_pkg::SSL_OFF_IRQ_CLEAR)
                     ? avs_writedata_i[NF-1:0] : '0;

  always_comb begin
    logic [7:0] merged;
    merged = 8'h00;
    next_state = state;
    next_state.flags_prev = flags;
    next_state.ack = access;
    // Set wins over a clear landing in the same cycle
    next_state.irq_status = (state.irq_status & ~clear_hit) | flag_change;
    // Straps are caught once, only when the sync stages hold pin values
    // rather than their reset zeros; flag edges seen while settling are dropped
    if (state.settle != 2'h3) begin
      next_state.settle = state.settle + 2'h1;
      next_state.irq_status = '0;
    end
    if (state.settle == ssl_pkg::SSL_STRAP_SETTLE) begin
      next_state.strap_latched = strap_sync;
      next_state.core_level = CW'(strap_core); // [R08]
      next_state.pll_level = PW'(strap_pll); // [R08]
    end
    // Writes land at the accepting edge, where waitrequest is low
    if (state.ack && avs_write_i) begin
      case (avs_address_i)
        ssl_pkg::SSL_OFF_CORE_LEVEL: begin
          merged = ssl_merge_low({1'b0, state.core_level}, avs_writedata_i,
                                 avs_byteenable_i);
          next_state.core_level = merged[CW-1:0]; // [R07] [R13]
        end
        ssl_pkg::SSL_OFF_PLL_LEVEL: begin
          merged = ssl_merge_low({5'h00, state.pll_level}, avs_writedata_i,
                                 avs_byteenable_i);
          next_state.pll_level = merged[PW-1:0]; // [R10] [R13]
        end
        ssl_pkg::SSL_OFF_IRQ_ENABLE: begin
          merged = ssl_merge_low({1'b0, state.irq_enable}, avs_writedata_i,
                                 avs_byteenable_i);
          next_state.irq_enable = merged[NF-1:0];
        end
        // Status is read-only: writes there are dropped
        ssl_pkg::SSL_OFF_STATUS: begin
          next_state.core_level = next_state.core_level; // [R06]
        end
        default: begin
          next_state.core_level = next_state.core_level;
        end
      endcase
    end
    next_state.rdata = 32'h0000_0000;
    if (access && avs_read_i) begin
      case (avs_address_i)
        ssl_pkg::SSL_OFF_STATUS: next_state.rdata = status_word; // [R06] [R13]
        ssl_pkg::SSL_OFF_CORE_LEVEL: next_state.rdata = {25'h000_0000, state.core_level};
        ssl_pkg::SSL_OFF_PLL_LEVEL: next_state.rdata = {29'h0000_0000, state.pll_level};
        ssl_pkg::SSL_OFF_IRQ_STATUS: next_state.rdata = {25'h000_0000, state.irq_status};
        ssl_pkg::SSL_OFF_IRQ_ENABLE: next_state.rdata = {25'h000_0000, state.irq_enable};
        ssl_pkg::SSL_OFF_STRAPS: next_state.rdata = {30'h0000_0000, state.strap_latched};
        default: next_state.rdata = ssl_pkg::SSL_UNMAPPED_DATA;
      endcase
    end
    if (!resetn_i) begin
      next_state = '0;
    end
  end

  always_ff @(posedge clock_i) begin
    state <= next_state;
  end

  // One wait cycle per access; the answer stands at the edge where wait drops
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !state.ack;
  assign avs_readdata_o = state.rdata;
  // Level codes drive the converters directly; slew is up to software
  assign core_buck_converter_level_o = state.core_level; // [R12] [R09]
  assign pll_linear_regulator_level_o = state.pll_level; // [R12] [R11]
  assign irq_o = |(state.irq_status & state.irq_enable);
endmodule // ssl_supply_regs

/* src/ssl_sync.sv */
`timescale 1ns/1ps
module ssl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } ssl_sync_state_t;
  ssl_sync_state_t state;
  ssl_sync_state_t next_state;
  // First stage feeds only the second stage
  always_comb begin
    next_state.first = async_i;
    next_state.second = state.first;
    if (!resetn_i) begin
      next_state = '0;
    end
  end
  always_ff @(posedge clock_i) begin
    state <= next_state;
  end
  assign sync_o = state.second;
endmodule // ssl_sync

/* verif/ssl_monitor.sv */
`timescale 1ns/1ps
module ssl_monitor (
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [ssl_pkg::SSL_STRAP_W-1:0] strap_i,
  input wire logic osc_stable_i,
  input wire logic pll_supply_rail_good_i,
  input wire logic core_supply_rail_good_i,
  input wire logic analogue_buck_converter_ilim_i,
  input wire logic core_buck_converter_ilim_i,
  input wire logic analogue_buck_converter_soft_i,
  input wire logic core_buck_converter_soft_i,
  input wire logic [ssl_pkg::SSL_CORE_LEVEL_W-1:0] core_buck_converter_level_o,
  input wire logic [ssl_pkg::SSL_PLL_LEVEL_W-1:0] pll_linear_regulator_level_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  wire rd_ok = avs_read_i && !avs_waitrequest_o;
  wire wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  wire [6:0] wd_core = avs_writedata_i[6:0];
  wire [2:0] wd_pll = avs_writedata_i[2:0];
  wire [31:0] live = {7'h00, osc_stable_i, 4'h0, pll_supply_rail_good_i, 2'h0,
    core_supply_rail_good_i, 6'h00, analogue_buck_converter_ilim_i, core_buck_converter_ilim_i,
    6'h00, analogue_buck_converter_soft_i, core_buck_converter_soft_i};
  logic [31:0] live_q;
  logic [2:0] quiet;
  // Flags pass a two-flop synchroniser, so flag bits are judged only on reads of a settled word
  always_ff @(posedge clock_i) begin
    live_q <= live;
    quiet <= (!resetn_i || live != live_q) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
  end
  wire st_rd = rd_ok && avs_address_i == ssl_pkg::SSL_OFF_STATUS;
  wire calm = st_rd && quiet > 3'h4;
  wire core_acc = avs_address_i == ssl_pkg::SSL_OFF_CORE_LEVEL;
  wire pll_acc = avs_address_i == ssl_pkg::SSL_OFF_PLL_LEVEL;
  a_osc_flag: assert property (calm |-> avs_readdata_o[24] == live[24])
    else $error("oscillator flag wrong");
  a_rail_good: assert property (calm |-> avs_readdata_o[19:16] == live[19:16])
    else $error("rail good flags wrong");
  a_ilim_flags: assert property (calm |-> avs_readdata_o[9:8] == live[9:8])
    else $error("current limit flags wrong");
  a_soft_flags: assert property (calm |-> avs_readdata_o[1:0] == live[1:0])
    else $error("soft-start flags wrong");
  a_status_resv: assert property (st_rd |-> (avs_readdata_o & ~ssl_pkg::SSL_STATUS_MASK) == 0)
    else $error("status reserved bits set");
  a_core_read: assert property (rd_ok && core_acc |-> avs_readdata_o == {25'h0, core_buck_converter_level_o})
    else $error("core level readback wrong");
  a_pll_read: assert property (rd_ok && pll_acc |-> avs_readdata_o == {29'h0, pll_linear_regulator_level_o})
    else $error("pll level readback wrong");
  a_core_write: assert property (wr_ok && core_acc |=> core_buck_converter_level_o == $past(wd_core))
    else $error("core level write lost");
  a_pll_write: assert property (wr_ok && pll_acc |=> pll_linear_regulator_level_o == $past(wd_pll))
    else $error("pll level write lost");
  a_reset_level: assert property ($rose(resetn_i) |-> ##3
    core_buck_converter_level_o == ssl_pkg::SSL_STRAP_CORE_LEVEL[strap_i]
    && pll_linear_regulator_level_o == ssl_pkg::SSL_STRAP_PLL_LEVEL[strap_i])
    else $error("level reset value wrong");
  a_wait_once: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest held too long");
  cover property (calm);
  cover property (wr_ok && core_acc);
  cover property (rd_ok && pll_acc);
  cover property ($rose(resetn_i) && strap_i != 2'h0);
endmodule // ssl_monitor
bind ssl_supply_regs ssl_monitor ssl_monitor_inst (.*);

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0000_0000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [6:0] flags = 7'h00;
  logic [6:0] core_level;
  logic [2:0] pll_level;
  logic irq_o;
  logic [31:0] exp_q[$];
  logic [31:0] r;
  logic [6:0] lvl;
  logic [1:0] strap = 2'h0;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32'hae236322;
  ssl_supply_regs ssl_supply_regs_inst (.clock_i(clock_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .strap_i(strap), .osc_stable_i(flags[6]),
    .pll_supply_rail_good_i(flags[5]), .core_supply_rail_good_i(flags[4]),
    .analogue_buck_converter_ilim_i(flags[3]), .core_buck_converter_ilim_i(flags[2]),
    .analogue_buck_converter_soft_i(flags[1]), .core_buck_converter_soft_i(flags[0]),
    .core_buck_converter_level_o(core_level), .pll_linear_regulator_level_o(pll_level),
    .irq_o(irq_o));
  initial forever #5 clock_i = !clock_i;
  task automatic end_sim;
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s at %0t: got %h want %h", what, $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
    chk("read data", got, exp);
  endtask
  task automatic chk_lvl(input logic [31:0] got, input logic [31:0] exp);
    chk("level", got, exp);
  endtask
  task automatic chk_irq(input logic got, input logic exp);
    chk("interrupt", {31'h0, got}, {31'h0, exp});
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    @(posedge clock_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clock_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task automatic strap_chk;
    rd(8'h34, {25'h0, ssl_pkg::SSL_STRAP_CORE_LEVEL[strap]});
    rd(8'h40, {29'h0, ssl_pkg::SSL_STRAP_PLL_LEVEL[strap]});
    rd(8'h5C, {30'h0, strap});
  endtask
  task automatic irq_step(input logic [7:0] a, input logic [31:0] d, input logic e);
    bus(1'b1, a, d);
    repeat (3) @(posedge clock_i);
    chk_irq(irq_o, e);
  endtask
  // Read data is judged at the accepting edge, before the design's registers move
  always @(posedge clock_i)
    if (avs_read_i && avs_waitrequest_o === 1'b0) chk_rd(avs_readdata_o, exp_q.pop_front());
  initial begin
    repeat (5000) @(posedge clock_i);
    err_total++;
    end_sim;
  end
  initial begin
    repeat (10) @(posedge clock_i);
    strap <= 2'($random(seed));
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    strap_chk;
    for (int i = 0; i < 12; i++) begin
      flags <= 7'($random(seed));
      repeat (8) @(posedge clock_i);
      bus(1'b1, 8'h30, $random(seed));
      rd(8'h30, {7'h00, flags[6], 4'h0, flags[5], 2'h0, flags[4], 6'h00, flags[3:2], 6'h00,
        flags[1:0]});
    end
    // Core level moves one 10 mV code per microsecond at most
    lvl = ssl_pkg::SSL_STRAP_CORE_LEVEL[strap];
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      lvl = r[0] ? lvl + 7'h01 : lvl - 7'h01;
      repeat (100) @(posedge clock_i);
      bus(1'b1, 8'h34, {r[31:7], lvl});
      rd(8'h34, {25'h0, lvl});
      chk_lvl({25'h0, core_level}, {25'h0, lvl});
    end
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      bus(1'b1, 8'h40, {r[31:3], 3'(i)});
      rd(8'h40, 32'(i));
      chk_lvl({29'h0, pll_level}, 32'(i));
    end
    bus(1'b1, 8'h44, 32'hFFFF_FFFF);
    rd(8'h44, ssl_pkg::SSL_UNMAPPED_DATA);
    bus(1'b1, 8'h58, 32'h0000_007F);
    flags <= flags ^ 7'h01;
    irq_step(8'h54, 32'h0000_0001, 1'b1);
    rd(8'h50, 32'h0000_0001);
    irq_step(8'h54, 32'h0000_0000, 1'b0);
    irq_step(8'h54, 32'h0000_0001, 1'b1);
    irq_step(8'h58, 32'h0000_0001, 1'b0);
    // Flag edge and clear meet at the same edge: the set must win
    flags <= flags ^ 7'h01;
    irq_step(8'h58, 32'h0000_0001, 1'b1);
    rd(8'h50, 32'h0000_0001);
    irq_step(8'h58, 32'h0000_007F, 1'b0);
    strap <= ~strap;
    resetn_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    strap_chk;
    end_sim;
  end
endmodule // testbench
